// ---- rtl/clock_channel_pkg.sv ----
// package of constants and types for the generic clock channel control block
// Summary of operation
// R1 - busy flag sets when synchronization starts
// R2 - busy flag clears when synchronization ends
// R3 - freeze bit locks channel and generator
// R4 - only power reset releases a freeze
// R5 - generator zero is never frozen
// R6 - gate bit stops or delivers channel clock
// R7 - generator field picks generator zero to eight
// R8 - selector field picks configured channel
// R9 - selector codes map consumers up to 0x24
// R10 - power reset reinitializes every channel
// R11 - user reset spares locked and rtc channels
// R12 - watchdog powers up on generator two
// R13 - watchdog freeze follows always-on nvm bit
// R14 - rtc cleared on user reset if idle
// R15 - unlocked watchdog returns to generator two
// R16 - other unlocked channels clear, locks kept
// R17 - write selector, then read that channel back
// R18 - software disables before changing generator
// R19 - writes to a frozen channel are ignored
// R20 - stall generator writes while synchronization is busy
// R21 - reserved codes deliver no clock, harmless
package clock_channel_pkg;

  // ****************************************
  // register map (printed offsets are indexes)
  // ****************************************
  localparam logic [3:0]  IDX_SYNC_STATUS   = 4'h1;  // sync_status index
  localparam logic [3:0]  IDX_CHANNEL_CTRL  = 4'h2;  // channel_clock_control index
  localparam logic [3:0]  IDX_GEN_CTRL      = 4'h4;  // generator control index
  localparam logic [31:0] ADDR_SYNC_STATUS  = {26'h0, IDX_SYNC_STATUS, 2'h0};
  localparam logic [31:0] ADDR_CHANNEL_CTRL = {26'h0, IDX_CHANNEL_CTRL, 2'h0};
  localparam logic [31:0] ADDR_GEN_CTRL     = {26'h0, IDX_GEN_CTRL, 2'h0};

  // ****************************************
  // field positions
  // ****************************************
  localparam int SYNC_BIT   = 7;   // sync_in_progress
  localparam int FREEZE_BIT = 15;  // config_freeze
  localparam int GATE_BIT   = 14;  // channel_gate_on
  localparam int GEN_LSB    = 8;   // source_generator_select low bit
  localparam int SEL_LSB    = 0;   // channel_selector low bit

  // ****************************************
  // channels and generators
  // ****************************************
  localparam int          NUM_CHANNELS = 37;       // codes 0x00 to 0x24
  localparam int          NUM_GENS     = 9;        // generators 0 to 8
  localparam logic [5:0]  CH_WATCHDOG  = 6'h03;    // watchdog_clock_channel
  localparam logic [5:0]  CH_RTC       = 6'h04;    // rtc_clock_channel
  localparam logic [5:0]  CH_UNUSED_A  = 6'h06;
  localparam logic [5:0]  CH_UNUSED_B  = 6'h20;
  localparam logic [5:0]  CH_UNUSED_C  = 6'h22;
  localparam logic [5:0]  CH_LAST      = 6'h24;
  localparam logic [3:0]  GEN_ZERO     = 4'h0;     // generator_zero
  localparam logic [3:0]  GEN_WATCHDOG = 4'h2;     // watchdog default source
  localparam logic [3:0]  GEN_LAST     = 4'h8;

  // cycles the status flag stays busy after a generator write
  localparam int          SYNC_TIME_NS = 20;
  localparam int          CLK_PERIOD_NS = 5;
  localparam logic [3:0]  SYNC_CYCLES  = 4'((SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       freeze;   // config_freeze
    logic       gate_on;  // channel_gate_on
    logic [3:0] gen;      // source_generator_select
  } chan_cfg_s;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT} bus_state_e;

endpackage

// ---- rtl/clock_channel_ctrl.sv ----
// generic clock channel control with ahb-lite register slave
`timescale 1ns/10ps
module clock_channel_ctrl
  import clock_channel_pkg::*;
(
  input  wire logic                    MCLK,        // 200 mhz system clock
  input  wire logic                    SYS_RST,     // power reset, async high
  input  wire logic                    USER_RST,    // user reset request pulse
  input  wire logic                    NVM_WDT_EN,  // nvm watchdog enable bit
  input  wire logic                    NVM_WDT_AON, // nvm watchdog always-on bit
  input  wire logic                    HSEL,
  input  wire logic [31:0]             HADDR,
  input  wire logic [1:0]              HTRANS,
  input  wire logic                    HWRITE,
  input  wire logic [2:0]              HSIZE,
  input  wire logic [31:0]             HWDATA,
  input  wire logic                    HREADY,
  output logic      [31:0]             HRDATA,
  output logic                         HREADYOUT,
  output logic                         HRESP,
  output logic      [NUM_CHANNELS-1:0] CHAN_GATE,   // per channel clock enable
  output logic      [NUM_CHANNELS*4-1:0] CHAN_GEN,  // per channel generator
  output logic      [NUM_GENS-1:0]     GEN_FROZEN   // per generator lock
);

  // ****************************************
  // storage
  // ****************************************
  chan_cfg_s    cfg_r [NUM_CHANNELS];  // per channel settings
  logic [5:0]   sel_r;                 // last written channel_selector
  logic [NUM_GENS-1:0] gen_lock_r;     // generators frozen by a channel
  logic [3:0]   sync_cnt_r;            // cycles left of synchronization
  logic         wdt_en_s1_r;           // nvm strap synchronisers
  logic         wdt_en_r;
  logic         wdt_aon_s1_r;
  logic         wdt_aon_r;
  logic         urst_s1_r;             // user reset synchroniser
  logic         urst_r;
  logic         nvm_load_r;            // pending nvm capture after release
  logic [1:0]   nvm_wait_r;            // strap settle count
  bus_state_e   bus_r;
  logic [31:0]  addr_r;
  logic         write_r;
  logic [31:0]  rdata_nxt;

  // valid channel code check, unused codes are no consumer
  // R9 consumer code map
  function automatic logic chan_ok(input logic [5:0] c);
    chan_ok = (c <= CH_LAST) && (c != CH_UNUSED_A) && (c != CH_UNUSED_B)
              && (c != CH_UNUSED_C);
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  // two flops on each nvm strap input and on the user reset input
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wdt_en_s1_r  <= 1'b0;
      wdt_en_r     <= 1'b0;
      wdt_aon_s1_r <= 1'b0;
      wdt_aon_r    <= 1'b0;
      urst_s1_r    <= 1'b0;
      urst_r       <= 1'b0;
    end else begin
      wdt_en_s1_r  <= NVM_WDT_EN;
      wdt_en_r     <= wdt_en_s1_r;
      wdt_aon_s1_r <= NVM_WDT_AON;
      wdt_aon_r    <= wdt_aon_s1_r;
      urst_s1_r    <= USER_RST;
      urst_r       <= urst_s1_r;
    end
  end

  // nvm straps are applied once they have passed the synchronisers
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      nvm_wait_r <= 2'h0;
      nvm_load_r <= 1'b0;
    end else begin
      nvm_load_r <= (nvm_wait_r == 2'h2);
      if (nvm_wait_r != 2'h3) begin
        nvm_wait_r <= nvm_wait_r + 2'h1;
      end
    end
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  wire addr_phase = HSEL && HTRANS[1] && HREADY;
  wire busy       = (sync_cnt_r != 4'h0);
  wire wr_done    = (bus_r == BUS_WAIT) && write_r && !(busy && addr_r == ADDR_GEN_CTRL);
  // R17 write selector first
  wire [5:0] w_sel  = HWDATA[SEL_LSB +: 6];
  wire [3:0] w_gen  = HWDATA[GEN_LSB +: 4];
  wire       ch_wr  = wr_done && addr_r == ADDR_CHANNEL_CTRL;
  wire       gen_wr = wr_done && addr_r == ADDR_GEN_CTRL;

  // address phase capture and data phase completion
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_r   <= BUS_IDLE;
      addr_r  <= 32'h0;
      write_r <= 1'b0;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (addr_phase) begin
            bus_r   <= BUS_WAIT;
            addr_r  <= {HADDR[31:2], 2'h0};
            write_r <= HWRITE;
          end
        end
        BUS_WAIT: begin
          // R20 hold generator writes while busy
          if (!write_r || wr_done) begin
            bus_r <= BUS_IDLE;
          end
        end
        default: bus_r <= BUS_IDLE;
      endcase
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rdata_nxt = 32'h0;
    if (addr_r == ADDR_SYNC_STATUS) begin
      rdata_nxt[SYNC_BIT] = busy;
    end else if (addr_r == ADDR_CHANNEL_CTRL && chan_ok(sel_r)) begin
      // R17 selected channel read back
      rdata_nxt[FREEZE_BIT]     = cfg_r[sel_r].freeze;
      rdata_nxt[GATE_BIT]       = cfg_r[sel_r].gate_on;
      rdata_nxt[GEN_LSB +: 4]   = cfg_r[sel_r].gen;
      rdata_nxt[SEL_LSB +: 6]   = sel_r;
    end else if (addr_r == ADDR_CHANNEL_CTRL) begin
      rdata_nxt[SEL_LSB +: 6]   = sel_r;
    end
  end

  // registered bus outputs
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HRDATA    <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      if (addr_phase && bus_r == BUS_IDLE) begin
        HREADYOUT <= 1'b0;
      end else if (bus_r == BUS_WAIT && (!write_r || wr_done)) begin
        HREADYOUT <= 1'b1;
        HRDATA    <= rdata_nxt;
      end
    end
  end

  // ****************************************
  // synchronization busy counter
  // ****************************************
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync_cnt_r <= 4'h0;
    end else if (gen_wr) begin
      // R1 set on start
      sync_cnt_r <= SYNC_CYCLES;
    end else if (busy) begin
      // R2 clear when done
      sync_cnt_r <= sync_cnt_r - 4'h1;
    end
  end

  // ****************************************
  // channel configuration
  // ****************************************
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // R10 power reset clears all channels, watchdog source set to generator two
      sel_r <= 6'h0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        cfg_r[i] <= '0;
      end
      cfg_r[CH_WATCHDOG].gen <= GEN_WATCHDOG;
    end else begin
      if (ch_wr) begin
        // R8 selector always updates
        sel_r <= w_sel;
      end
      if (nvm_load_r) begin
        // R12 watchdog gate from nvm
        cfg_r[CH_WATCHDOG].gate_on <= wdt_en_r;
        // R13 watchdog freeze from nvm
        cfg_r[CH_WATCHDOG].freeze  <= wdt_aon_r;
      end else if (urst_r) begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
          // R11 rtc and frozen channels spared
          if (!cfg_r[i].freeze && 6'(i) == CH_RTC) begin
            // R14 rtc clears only if gated off
            if (!cfg_r[i].gate_on) begin
              cfg_r[i].gen <= GEN_ZERO;
            end
          end else if (!cfg_r[i].freeze && 6'(i) == CH_WATCHDOG) begin
            // R15 watchdog to its default source
            cfg_r[i].gen     <= GEN_WATCHDOG;
            cfg_r[i].gate_on <= wdt_en_r;
          end else if (!cfg_r[i].freeze) begin
            // R16 others cleared, freeze kept
            cfg_r[i].gen     <= GEN_ZERO;
            cfg_r[i].gate_on <= 1'b0;
          end
        end
      end else if (ch_wr && chan_ok(w_sel) && !cfg_r[w_sel].freeze) begin
        // R19 frozen channel ignores writes
        cfg_r[w_sel].gate_on <= HWDATA[GATE_BIT];
        cfg_r[w_sel].gen     <= w_gen;
        // R3 freeze request, R4 sticky
        cfg_r[w_sel].freeze  <= HWDATA[FREEZE_BIT];
      end
    end
  end

  // generator lock, set by a frozen channel, cleared only by power reset
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gen_lock_r <= '0;
    end else begin
      for (int g = 1; g < NUM_GENS; g++) begin
        // R5 generator zero never locked
        for (int i = 0; i < NUM_CHANNELS; i++) begin
          if (cfg_r[i].freeze && cfg_r[i].gen == 4'(g)) begin
            gen_lock_r[g] <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // clock gate outputs
  // ****************************************
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CHAN_GATE  <= '0;
      CHAN_GEN   <= '0;
      GEN_FROZEN <= '0;
    end else begin
      GEN_FROZEN <= gen_lock_r;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        // R6 gate bit, R7 and R21 reserved source gives no clock
        CHAN_GATE[i]      <= cfg_r[i].gate_on && (cfg_r[i].gen <= GEN_LAST)
                             && chan_ok(6'(i));
        CHAN_GEN[i*4 +: 4] <= cfg_r[i].gen;
      end
    end
  end

endmodule

// ---- test/clock_channel_ctrl_asserts.sv ----
// concurrent checks on the ports of the clock channel control block
`timescale 1ns/10ps
module clock_channel_ctrl_asserts
  import clock_channel_pkg::*;
(
  input wire logic                      MCLK,
  input wire logic                      SYS_RST,
  input wire logic                      HSEL,
  input wire logic [1:0]                HTRANS,
  input wire logic                      HWRITE,
  input wire logic                      HREADY,
  input wire logic                      HREADYOUT,
  input wire logic                      HRESP,
  input wire logic [NUM_CHANNELS-1:0]   CHAN_GATE,
  input wire logic [NUM_CHANNELS*4-1:0] CHAN_GEN,
  input wire logic [NUM_GENS-1:0]       GEN_FROZEN
);
  logic bad_gen; // some gated channel sits on a reserved generator code
  // scan every channel for a live clock on a reserved code
  always_comb begin
    bad_gen = 1'b0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (CHAN_GATE[i] && CHAN_GEN[4*i+:4] > GEN_LAST) bad_gen = 1'b1;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  a_gen0_free: assert property (GEN_FROZEN[0] == 1'b0)
    else $error("generator zero frozen");
  a_reserved_dark: assert property (!bad_gen)
    else $error("clock delivered from reserved generator");
  a_unused_dark: assert property (!CHAN_GATE[6] && !CHAN_GATE[32] && !CHAN_GATE[34])
    else $error("unused channel gated on");
  a_ready_drop: assert property (HSEL && HTRANS[1] && HREADY && HREADYOUT |=> !HREADYOUT)
    else $error("taken transfer did not wait");
  a_stall_bound: assert property ($fell(HREADYOUT) |-> ##[1:20] HREADYOUT)
    else $error("bus stall never ended");
  a_freeze_hold: assert property ((GEN_FROZEN & $past(GEN_FROZEN)) == $past(GEN_FROZEN))
    else $error("freeze released without power reset");
  a_wdt_source: assert property ($fell(SYS_RST) |=> CHAN_GEN[15:12] == GEN_WATCHDOG)
    else $error("watchdog channel not on generator two");
  a_reset_dark: assert property ($fell(SYS_RST) |-> CHAN_GATE == '0 && GEN_FROZEN == '0)
    else $error("state left over from before power reset");
  c_write: cover property (HSEL && HTRANS[1] && HREADY && HWRITE);
  c_freeze: cover property ($rose(GEN_FROZEN[4]));
  c_stall: cover property (!HREADYOUT [*2]);
endmodule
bind clock_channel_ctrl clock_channel_ctrl_asserts chk_u (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CHAN_GATE(CHAN_GATE),
  .CHAN_GEN(CHAN_GEN), .GEN_FROZEN(GEN_FROZEN)
);

// ---- test/ahb_bus_master.sv ----
// ahb-lite master model standing in for the processor bus
`timescale 1ns/10ps
module ahb_bus_master (
  input  wire logic        MCLK,
  input  wire logic        HREADYOUT,
  output logic             HSEL,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [31:0]      HWDATA
);
  logic rdph = 1'b0; // a read data phase is in flight
  initial begin
    HSEL = 1'b1;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
  end
  // one single word transfer; n returns the data phase edges
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output int n);
    n = 0;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do begin @(posedge MCLK); n++; end while (HREADYOUT !== 1'b1 && n < 200);
    // a hung address phase is reported through n
    if (n >= 200) return;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdph <= !w;
    n = 0;
    // wait out a stalled data phase
    do begin @(posedge MCLK); n++; end while (HREADYOUT !== 1'b1 && n < 200);
    rdph <= 1'b0;
  endtask
endmodule

// ---- test/clock_channel_ctrl_tb.sv ----
// self-checking bench for the clock channel control block
`timescale 1ns/10ps
module clock_channel_ctrl_tb import clock_channel_pkg::*;;
  logic MCLK = 0, SYS_RST = 1, USER_RST = 0, NVM_WDT_EN = 1, NVM_WDT_AON = 1;
  logic                      HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0]               HADDR, HWDATA, HRDATA;
  logic [1:0]                HTRANS;
  logic [2:0]                HSIZE;
  logic [NUM_CHANNELS-1:0]   CHAN_GATE;
  logic [NUM_CHANNELS*4-1:0] CHAN_GEN;
  logic [NUM_GENS-1:0]       GEN_FROZEN;
  int                        n_errors = 0, compares = 0, n;
  logic [31:0]               exp_q[$]; // expected read data, oldest first
  logic [3:0]                g;        // random source generator
  always #2.5 MCLK = ~MCLK;
  clock_channel_ctrl dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .USER_RST(USER_RST),
    .NVM_WDT_EN(NVM_WDT_EN), .NVM_WDT_AON(NVM_WDT_AON), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CHAN_GATE(CHAN_GATE),
    .CHAN_GEN(CHAN_GEN), .GEN_FROZEN(GEN_FROZEN));
  ahb_bus_master m_u (.MCLK(MCLK), .HREADYOUT(HREADYOUT), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge MCLK);
  endtask
  // one bus transfer; a hung bus ends the run
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    m_u.xfer(w, a, d, n);
    if (n >= 200) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic urst();
    USER_RST <= 1'b1;
    wt(1);
    USER_RST <= 1'b0;
    wt(8);
  endtask
  // compare each completed read with the oldest expectation
  always @(posedge MCLK)
    if (m_u.rdph && HREADYOUT) chk(HRDATA, exp_q.pop_front());
  initial begin
    void'($urandom(32'h2508b471));
    g = 4'(1 + $urandom % 8);
    wt(2);
    SYS_RST <= 1'b0;
    wt(8);
    chk(32'({CHAN_GATE[3], GEN_FROZEN[2], CHAN_GEN[15:12]}), 32'h32);
    rd(ADDR_SYNC_STATUS, 32'h0);
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h0003);
    rd(ADDR_CHANNEL_CTRL, 32'hc203);
    // source change: disable, confirm, new source, enable
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h0005);
    rd(ADDR_CHANNEL_CTRL, 32'h0005);
    bus(1'b1, ADDR_CHANNEL_CTRL, {20'h0, g, 8'h05});
    bus(1'b1, ADDR_CHANNEL_CTRL, {16'h0, 4'h4, g, 8'h05});
    rd(ADDR_CHANNEL_CTRL, {16'h0, 4'h4, g, 8'h05});
    wt(3);
    chk(32'({CHAN_GATE[5], CHAN_GEN[23:20]}), {27'h0, 1'b1, g});
    // every generator code on channel ten, unused codes stay dark
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, ADDR_CHANNEL_CTRL, 32'h000a);
      bus(1'b1, ADDR_CHANNEL_CTRL, {16'h0, 4'h4, 4'(k), 8'h0a});
      wt(3);
      chk(32'(CHAN_GATE[10]), 32'(k <= 8));
    end
    bus(1'b1, ADDR_CHANNEL_CTRL, {16'h0, 8'h41, 2'h0, CH_UNUSED_B});
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h4122);
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h4106);
    wt(3);
    chk(32'({CHAN_GATE[6], CHAN_GATE[32], CHAN_GATE[34]}), 32'h0);
    // freeze channel eight, then try to change it
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'hc408);
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h0108);
    rd(ADDR_CHANNEL_CTRL, 32'hc408);
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'hc009);
    wt(3);
    chk(32'(GEN_FROZEN[4:0]), 32'h14);
    // generator writes back to back: the second one stalls
    bus(1'b1, ADDR_GEN_CTRL, 32'h1);
    bus(1'b1, ADDR_GEN_CTRL, 32'h1);
    chk(32'(n > 2), 32'h1);
    rd(ADDR_SYNC_STATUS, 32'h80);
    wt(10);
    rd(ADDR_SYNC_STATUS, 32'h0);
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h4304);
    urst();
    chk(32'({CHAN_GATE[5], CHAN_GATE[4], CHAN_GATE[8], CHAN_GATE[3]}), 32'h7);
    chk(32'({CHAN_GEN[23:20], CHAN_GEN[19:16], CHAN_GEN[35:32]}), 32'h034);
    chk(32'(GEN_FROZEN[4:0]), 32'h14);
    // power reset with the watchdog left unfrozen
    NVM_WDT_AON <= 1'b0;
    SYS_RST <= 1'b1;
    wt(2);
    SYS_RST <= 1'b0;
    wt(8);
    chk(32'({CHAN_GATE[8], CHAN_GATE[4], GEN_FROZEN}), 32'h0);
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h4503);
    bus(1'b1, ADDR_CHANNEL_CTRL, 32'h0304);
    urst();
    chk(32'({CHAN_GATE[3], CHAN_GEN[15:12], CHAN_GEN[19:16]}), 32'h120);
    test_done();
  end
endmodule
